// ### core/axil_reg_port.sv
// AXI4-Lite slave front end: turns bus handshakes into one-cycle register
// write and read strikes with a word index.
// Assumes one clock, active-low asynchronous reset, 7-bit decoded window.
`timescale 1ns/1ps
`default_nettype none
`include "irq_en_map.svh"

module axil_reg_port (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write address and data
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic wrFire,
  output logic [4:0] wrIdx,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic rdFire,
  output logic [4:0] rdIdx,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);

  logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
  logic [4:0] awIdx_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;

  // Address and data may come in either order; each is held until both
  assign awready = !awHeld_q && !bvalid_q;
  assign wready = !wHeld_q && !bvalid_q;
  assign wrFire = (awHeld_q || awvalid) && (wHeld_q || wvalid) && !bvalid_q;
  assign wrIdx = awHeld_q ? awIdx_q : awaddr[6:2];
  assign wrData = wHeld_q ? wData_q : wdata;
  assign wrStrb = wHeld_q ? wStrb_q : wstrb;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // Write channel capture and response
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bvalid_q <= 1'b0;
      awIdx_q <= 5'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
    end else if (wrFire) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bvalid_q <= 1'b1;
      bresp_q <= wrErr ? `RESP_SLVERR : `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awIdx_q <= awaddr[6:2];
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: data registered on the same edge that takes the address
  assign arready = !rvalid_q;
  assign rdFire = arvalid && !rvalid_q;
  assign rdIdx = araddr[6:2];
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (rdFire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdData;
      rresp_q <= rdErr ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### core/interrupt_enable_registers.sv
// Interrupt enable register bank: three enable registers, request flags,
// per-source priority fields and one level interrupt, on AXI4-Lite.
// Assumes request inputs synchronous to clk and priority logic downstream.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_en_map.svh"

module interrupt_enable_registers (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AXI4-Lite write address and data
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Peripheral request sources, bit 16*reg+bit
  input wire logic [47:0] srcEvent,
  // Towards the priority logic
  output logic [47:0] gatedReq,
  output logic [143:0] srcPrio,
  output logic irq
);

  // ========================================================================
  // Helper functions
  // ========================================================================

  // Which register an index selects
  function automatic irq_en_pkg::reg_kind_t kindOf(input logic [4:0] idx);
    if (idx <= `IDX_EN2) begin
      return irq_en_pkg::KIND_EN;
    end else if (idx <= `IDX_FLAG2) begin
      return irq_en_pkg::KIND_FLAG;
    end else if (idx <= `IDX_PEND2) begin
      return irq_en_pkg::KIND_PEND;
    end else if (idx >= `IDX_PRIO0 && idx <= `IDX_PRIO11) begin
      return irq_en_pkg::KIND_PRIO;
    end
    return irq_en_pkg::KIND_NONE;
  endfunction

  // Merge a bus write into a 16-bit register by byte strobe
  function automatic irq_en_pkg::word16_t applyStrobe(input irq_en_pkg::word16_t old,
                                                       input logic [31:0] d,
                                                       input logic [3:0] s);
    irq_en_pkg::word16_t w;
    w = old;
    if (s[0]) begin
      w[7:0] = d[7:0];
    end
    if (s[1]) begin
      w[15:8] = d[15:8];
    end
    return w;
  endfunction

  // Four priority fields of one priority register, gaps read zero
  function automatic irq_en_pkg::word16_t prioWord(input logic [143:0] p,
                                                    input logic [3:0] r);
    irq_en_pkg::word16_t w;
    int s;
    w = 16'h0000;
    for (int f = 0; f < 4; f++) begin
      s = 4 * int'(r) + f;
      w[4 * f +: 3] = p[3 * s +: 3];
    end
    return w;
  endfunction

  // ========================================================================
  // Bus front end
  // ========================================================================
  logic wrFire, rdFire;
  logic [4:0] wrIdx, rdIdx;
  logic [31:0] wrData, rdData;
  logic [3:0] wrStrb;
  irq_en_pkg::reg_kind_t wrKind, rdKind;

  axil_reg_port busPort (
    .clk(clk),
    .resetn(resetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrFire(wrFire),
    .wrIdx(wrIdx),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrKind == irq_en_pkg::KIND_NONE),
    .rdFire(rdFire),
    .rdIdx(rdIdx),
    .rdData(rdData),
    .rdErr(rdKind == irq_en_pkg::KIND_NONE)
  );

  // ========================================================================
  // Decode and implemented-bit layout
  // ========================================================================
  logic [47:0] implMask, enQ, enD, flagQ, clrMask, prioLive;
  logic [143:0] prioQ, prioD;
  logic [5:0] wrEnBase, wrFlagBase, rdBase;
  logic [3:0] wrPrioReg, rdPrioReg;

  // Register kinds and word bases for both bus directions
  assign wrKind = kindOf(wrIdx);
  assign rdKind = kindOf(rdIdx);
  assign wrEnBase = {wrIdx[1:0], 4'h0};
  assign wrFlagBase = {2'(wrIdx - `IDX_FLAG0), 4'h0};
  assign wrPrioReg = 4'(wrIdx - `IDX_PRIO0);
  assign rdPrioReg = 4'(rdIdx - `IDX_PRIO0);

  // Source positions; enable register k bit b gates source 16*k+b
  assign implMask[15:8] = 8'hFF;
  assign implMask[7:0] = 8'hFF;
  assign implMask[31:24] = 8'hFF;
  assign implMask[23:16] = 8'hFF;
  assign implMask[44:40] = 5'h1F;
  assign implMask[39:32] = 8'hFF;
  assign implMask[47:45] = 3'h0;

  // ========================================================================
  // Enable registers
  // ========================================================================

  // Strobed write into the selected enable register
  always_comb begin
    enD = enQ;
    if (wrFire && wrKind == irq_en_pkg::KIND_EN) begin
      enD[wrEnBase +: 16] = applyStrobe(enQ[wrEnBase +: 16], wrData, wrStrb)
                            & implMask[wrEnBase +: 16];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enQ <= `EN_RESET;
    end else begin
      enQ <= enD;
    end
  end

  // ========================================================================
  // Priority fields
  // ========================================================================

  // Strobed write into one priority register, four sources per register
  always_comb begin
    irq_en_pkg::word16_t nw;
    int s;
    nw = applyStrobe(prioWord(prioQ, wrPrioReg), wrData, wrStrb);
    s = 0;
    prioD = prioQ;
    if (wrFire && wrKind == irq_en_pkg::KIND_PRIO) begin
      for (int f = 0; f < 4; f++) begin
        s = 4 * int'(wrPrioReg) + f;
        if (implMask[s]) begin
          prioD[3 * s +: 3] = nw[4 * f +: 3];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int s = 0; s < `SRC_COUNT; s++) begin
        prioQ[3 * s +: 3] <= (s < 45) ? `PRIO_RESET : `PRIO_OFF;
      end
    end else begin
      prioQ <= prioD;
    end
  end

  // A zero priority field switches its source off
  always_comb begin
    for (int s = 0; s < `SRC_COUNT; s++) begin
      prioLive[s] = prioQ[3 * s +: 3] != `PRIO_OFF;
    end
  end

  assign srcPrio = prioQ;

  // ========================================================================
  // Flags and gating
  // ========================================================================

  // Write-one-to-clear strike on the selected flag register
  always_comb begin
    clrMask = 48'h0000_0000_0000;
    if (wrFire && wrKind == irq_en_pkg::KIND_FLAG) begin
      clrMask[wrFlagBase +: 16] = applyStrobe(16'h0000, wrData, wrStrb);
    end
  end

  irq_flag_gate flagGate (
    .clk(clk),
    .resetn(resetn),
    .srcEvent(srcEvent),
    .clrMask(clrMask),
    .implMask(implMask),
    .enable(enQ),
    .prioLive(prioLive),
    .flagQ(flagQ),
    .gatedReq(gatedReq)
  );

  // One level interrupt while any gated request stands
  assign irq = |gatedReq;

  // ========================================================================
  // Read data
  // ========================================================================
  assign rdBase = {2'(rdIdx - ((rdKind == irq_en_pkg::KIND_EN) ? `IDX_EN0 :
                              (rdKind == irq_en_pkg::KIND_FLAG) ? `IDX_FLAG0 :
                              `IDX_PEND0)), 4'h0};

  // Selected register, upper half always zero
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (rdKind)
      irq_en_pkg::KIND_EN: rdData[15:0] = enQ[rdBase +: 16];
      irq_en_pkg::KIND_FLAG: rdData[15:0] = flagQ[rdBase +: 16];
      irq_en_pkg::KIND_PEND: rdData[15:0] = gatedReq[rdBase +: 16];
      irq_en_pkg::KIND_PRIO: rdData[15:0] = prioWord(prioQ, rdPrioReg);
      irq_en_pkg::KIND_NONE: rdData = 32'h0000_0000;
    endcase
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_CMP6_FLAG: assert property (
    srcEvent[`SRC_CMP6] |=> flagQ[`SRC_CMP6] ##0 (flagQ[`SRC_CMP6] || clrMask[`SRC_CMP6]))
    else $error("compare 6 request did not set its flag");

  AST_CMP5_FLAG: assert property (
    (srcEvent[`SRC_CMP5] && clrMask[`SRC_CMP5]) |=> flagQ[`SRC_CMP5])
    else $error("compare 5 flag lost to a same-cycle clear");

  AST_GATE_BLOCK: assert property (
    (gatedReq & ~enQ) == 48'h0000_0000_0000)
    else $error("request passed a disabled source");

  AST_EN_WRITE: assert property (
    (wrFire && wrIdx == `IDX_EN0 && wrStrb[1:0] == 2'h3) |=>
      enQ[15:0] == $past(wrData[15:0]))
    else $error("enable register 0 write not stored");

  AST_EN_HOLD: assert property (
    !(wrFire && wrKind == irq_en_pkg::KIND_EN) |=> $stable(enQ))
    else $error("enable register changed without a write");

  AST_UNIMPL: assert property (
    enQ[47:45] == 3'h0 && flagQ[47:45] == 3'h0)
    else $error("unimplemented enable bits became set");

  AST_LANE_UPPER: assert property (
    (wrFire && wrIdx == `IDX_EN0 && wrStrb[1:0] == 2'h2) |=> $stable(enQ[7:0]))
    else $error("upper byte write disturbed the lower byte");

  AST_PRIO_OFF: assert property (
    (gatedReq & ~prioLive) == 48'h0000_0000_0000)
    else $error("request passed with priority zero");

  AST_FLAG_GATE: assert property (
    $rose(gatedReq[`SRC_CMP6]) |-> flagQ[`SRC_CMP6] && enQ[`SRC_CMP6] && irq)
    else $error("gated request without flag and enable");

  AST_RESP_NEXT: assert property (
    wrFire |=> bvalid ##0 $past(bvalid) == 1'b0)
    else $error("write response not one cycle after the write");

  // Main scenarios
  COV_GATED: cover property (srcEvent[0] ##1 gatedReq[0] ##1 irq);
  COV_CLEAR: cover property (gatedReq[`SRC_CMP6] ##[1:20] !flagQ[`SRC_CMP6]);
  COV_BAD_ADDR: cover property (bvalid && bresp == `RESP_SLVERR);
  COV_PRIO_WR: cover property (wrFire && wrKind == irq_en_pkg::KIND_PRIO);

endmodule
`default_nettype wire

// ### core/irq_en_map.svh
// Register map, field layout, reset values and bus codes of the
// interrupt enable register bank.
// Assumes a 32-bit AXI4-Lite bus with word indices taken from address bits 6:2.
`ifndef IRQ_EN_MAP_SVH
`define IRQ_EN_MAP_SVH

// ==========================================================================
// Word indices (byte address = 4 * index)
// ==========================================================================
`define IDX_EN0 5'h00
`define IDX_EN2 5'h02
`define IDX_FLAG0 5'h03
`define IDX_FLAG2 5'h05
`define IDX_PEND0 5'h06
`define IDX_PEND2 5'h08
`define IDX_PRIO0 5'h10
`define IDX_PRIO11 5'h1B

// ==========================================================================
// Field layout and reset values
// ==========================================================================
`define SRC_COUNT 48
`define SRC_CMP5 32
`define SRC_CMP6 33
`define EN_RESET 48'h0000_0000_0000
`define FLAG_RESET 48'h0000_0000_0000
`define PRIO_RESET 3'h4
`define PRIO_OFF 3'h0

// ==========================================================================
// Bus response codes
// ==========================================================================
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### core/irq_en_pkg.sv
// Types shared by the interrupt enable register bank.
// Assumes the map header supplies all numbers.
package irq_en_pkg;

  // One 16-bit software register
  typedef logic [15:0] word16_t;

  // One source priority field
  typedef logic [2:0] prio_t;

  // All request sources, three registers of sixteen
  typedef logic [47:0] src_vec_t;

  // Kind of register an index selects
  typedef enum {KIND_EN, KIND_FLAG, KIND_PEND, KIND_PRIO, KIND_NONE} reg_kind_t;

endpackage

// ### core/irq_flag_gate.sv
// Sticky request flags for all implemented sources and the gate that lets a flagged,
// enabled, prioritised request through.
// Assumes request inputs synchronous to clk; clear mask is a one-cycle strike.
`timescale 1ns/1ps
`default_nettype none
`include "irq_en_map.svh"

module irq_flag_gate (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sources and controls
  input wire logic [47:0] srcEvent,
  input wire logic [47:0] clrMask,
  input wire logic [47:0] implMask,
  input wire logic [47:0] enable,
  input wire logic [47:0] prioLive,
  // Results
  output logic [47:0] flagQ,
  output logic [47:0] gatedReq
);

  logic [47:0] flag_q, flag_d;

  // Set wins over a clear in the same cycle, enable plays no part
  assign flag_d = ((flag_q & ~clrMask) | srcEvent) & implMask;
  assign flagQ = flag_q;

  // Flag storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= `FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Only flagged, enabled and non-zero priority requests pass
  assign gatedReq = flag_q & enable & prioLive;

endmodule
`default_nettype wire

// ### verif/irq_source_model.sv
// Model of the peripheral request sources feeding the enable bank.
// Assumes the bench asks for a pulse with a one-cycle go strobe.
`timescale 1ns/1ps
`default_nettype none

module irq_source_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bench command
  input wire logic [47:0] fireMask,
  input wire logic fireGo,
  // Requests towards the bank
  output logic [47:0] srcEvent
);
  // ==========================================================================
  // Request pulses
  // ==========================================================================
  // One-cycle pulse per command, idle low in between
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srcEvent <= 48'h0;
    end else begin
      srcEvent <= fireGo ? fireMask : 48'h0;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the interrupt enable register bank.
// Assumes the source model drives the request inputs and AXI4-Lite reaches registers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); end end

module tb_top;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rv;
  logic [47:0] srcEvent, gatedReq, en, fm, ex;
  logic [47:0] fireMask = 48'h0;
  logic fireGo = 1'b0;
  logic [143:0] srcPrio;
  logic [15:0] d;
  int k;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Clock, 4 ns period
  always #2 clk = ~clk;

  // ==========================================================================
  // Design and source model
  // ==========================================================================
  interrupt_enable_registers uut (
    .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .srcEvent(srcEvent), .gatedReq(gatedReq), .srcPrio(srcPrio), .irq(irq)
  );

  irq_source_model sources (
    .clk(clk), .resetn(resetn), .fireMask(fireMask), .fireGo(fireGo), .srcEvent(srcEvent)
  );

  // ==========================================================================
  // Expectations and bus tasks
  // ==========================================================================
  // Writable bits of each enable register
  function automatic logic [15:0] implMask(input int r);
    return (r == 2) ? 16'h1FFF : 16'hFFFF;
  endfunction

  // Priority register contents after reset
  function automatic logic [15:0] prioRst(input int p);
    return (p == 11) ? 16'h0004 : 16'h4444;
  endfunction

  // One write, address and data offered together
  task automatic axiWrite(input logic [4:0] idx, input logic [15:0] v, input logic [3:0] s);
    logic awDone;
    logic wDone;
    @(posedge clk);
    awaddr <= {25'h0, idx, 2'h0};
    wdata <= {16'h0, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awDone = 1'b0;
    wDone = 1'b0;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && awready === 1'b1) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready === 1'b1) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // One read, result left in rv and resp
  task automatic axiRead(input logic [4:0] idx);
    @(posedge clk);
    araddr <= {25'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Read and compare data and response
  task automatic chkRd(input logic [4:0] idx, input logic [31:0] exd, input logic [1:0] exr);
    axiRead(idx);
    `CHK("rdata", exd, rv)
    `CHK("rresp", exr, resp)
  endtask

  // Fire a request pulse and let flags settle
  task automatic fire(input logic [47:0] m);
    @(posedge clk);
    fireMask <= m;
    fireGo <= 1'b1;
    @(posedge clk);
    fireGo <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Counts and verdict, then end of run
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      $display("MISMATCH watchdog exp=done got=hang");
      summarize();
    end
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    rv = $urandom(32'h86FF);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    // Reset contents
    for (k = 0; k < 3; k++) chkRd(5'(k), 32'h0, 2'h0);
    for (k = 0; k < 12; k++) chkRd(5'(16 + k), {16'h0, prioRst(k)}, 2'h0);
    `CHK("irq", 1'b0, irq)
    // Random enable read/write
    repeat (24) begin
      k = $urandom % 3;
      d = 16'($urandom);
      axiWrite(5'(k), d, 4'hF);
      chkRd(5'(k), {16'h0, d & implMask(k)}, 2'h0);
    end
    axiWrite(5'h02, 16'hFFFF, 4'h3);
    chkRd(5'h02, 32'h0000_1FFF, 2'h0);
    axiWrite(5'h00, 16'h0000, 4'h3);
    axiWrite(5'h00, 16'hABCD, 4'h2);
    chkRd(5'h00, 32'h0000_AB00, 2'h0);
    axiWrite(5'h09, 16'hFFFF, 4'h3);
    `CHK("bresp", 2'h2, resp)
    chkRd(5'h09, 32'h0, 2'h2);
    // Random enables against random requests
    repeat (8) begin
      en = {16'($urandom), $urandom};
      fm = {16'($urandom), $urandom};
      for (k = 0; k < 3; k++) axiWrite(5'(k), en[16*k +: 16], 4'h3);
      fire(fm);
      ex = fm & en & 48'h1FFF_FFFF_FFFF;
      `CHK("gatedReq", ex, gatedReq)
      `CHK("irq", |ex, irq)
      for (k = 0; k < 3; k++) axiWrite(5'(3 + k), 16'hFFFF, 4'h3);
      `CHK("irq", 1'b0, irq)
    end
    for (k = 0; k < 3; k++) axiWrite(5'(k), 16'h0, 4'h3);
    // Each source alone: flag, block, pass, clear
    for (int s = 0; s < 45; s++) begin
      fire(48'h1 << s);
      chkRd(5'(3 + s / 16), {16'h0, 16'h1 << (s % 16)}, 2'h0);
      `CHK("gatedReq", 48'h0, gatedReq)
      axiWrite(5'(s / 16), 16'h1 << (s % 16), 4'h3);
      `CHK("gatedReq", 48'h1 << s, gatedReq)
      `CHK("irq", 1'b1, irq)
      chkRd(5'(6 + s / 16), {16'h0, 16'h1 << (s % 16)}, 2'h0);
      axiWrite(5'(3 + s / 16), 16'h1 << (s % 16), 4'h3);
      `CHK("irq", 1'b0, irq)
      axiWrite(5'(s / 16), 16'h0, 4'h3);
    end
    // A clear landing on the edge of a new compare 5 request loses to it
    fork
      fire(48'h0001_0000_0000);
      begin
        @(posedge clk);
        axiWrite(5'h05, 16'h0001, 4'h3);
      end
    join
    chkRd(5'h05, 32'h0000_0001, 2'h0);
    axiWrite(5'h05, 16'h0001, 4'h3);
    chkRd(5'h05, 32'h0, 2'h0);
    // Sources without an enable bit never flag
    fire(48'hE000_0000_0000);
    chkRd(5'h05, 32'h0, 2'h0);
    `CHK("gatedReq", 48'h0, gatedReq)
    // Priority zero holds back an enabled, flagged source
    axiWrite(5'h10, 16'h4440, 4'h3);
    axiWrite(5'h00, 16'h0001, 4'h3);
    fire(48'h1);
    `CHK("gatedReq", 48'h0, gatedReq)
    `CHK("srcPrio", 3'h0, srcPrio[2:0])
    axiWrite(5'h10, 16'h4447, 4'h3);
    `CHK("gatedReq", 48'h1, gatedReq)
    `CHK("srcPrio", 3'h7, srcPrio[2:0])
    chkRd(5'h10, 32'h0000_4447, 2'h0);
    summarize();
  end
endmodule
`default_nettype wire
